// ---- include/timer_one_consts.svh ----
// Purpose: Offsets, field positions, reset values and timing for timer one
// Assumes: 8-bit register port, byte offsets as printed
// Notes: Interrupt control offset and its enable bit position are local picks
`ifndef TIMER_ONE_CONSTS_SVH
`define TIMER_ONE_CONSTS_SVH

`define T1_ADDR_COUNT 8'h10
`define T1_ADDR_CONTROL 8'h11
`define T1_ADDR_INTCTL 8'h0B

`define T1_BIT_PRESCALE_LO 0
`define T1_BIT_EDGE 3
`define T1_BIT_ENABLE 4
`define T1_BIT_SOURCE 5
`define T1_BIT_MODE_LO 6
`define T1_BIT_MODE_HI 7

`define T1_BIT_IRQ_ENABLE 3
`define T1_BIT_IRQ_FLAG 6

`define T1_RESET_COUNT 8'h00
`define T1_RESET_PRELOAD 8'h00
`define T1_RESET_CONTROL 8'h00
`define T1_COUNT_TOP 8'hFF
`define T1_READ_ZERO 8'h00

`define T1_CLOCK_HZ 40000000
`define T1_RTC_HZ 32768

`endif

// ---- include/timer_one_pkg.sv ----
// Purpose: Types used by the timer one design only
// Assumes: Used as timer_one_pkg::name, never imported
// Notes: Control fields are laid out in register bit order, msb first
package timer_one_pkg;

  typedef enum logic [1:0] {
    MODE_UNUSED = 2'h0,
    MODE_EVENT = 2'h1,
    MODE_TIMER = 2'h2,
    MODE_PULSE = 2'h3
  } mode_t;

  typedef struct packed {
    mode_t mode;
    logic clock_source_select;
    logic count_enable_bit;
    logic active_edge_select;
    logic [2:0] prescale;
  } control_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef enum {
    PW_WAIT_START,
    PW_COUNTING
  } pulse_state_t;

endpackage

// ---- logic/timer_one.sv ----
// Purpose: 8-bit up-counting timer/event counter with preload, prescaler and
//          single-shot pulse-width measurement
// Assumes: All inputs synchronous to CLOCK; the 32 kHz clock arrives as a level
//          on RTC_CLK and is edge-detected here
// Notes: Register port has no wait states; read data stands one cycle only
//
// Overview of operation
// - Control bit 5 picks the internal source: 0 system clock, 1 the 32 kHz clock.
// - Control bits 2..0 divide the source by 2 at code 000, doubling to 256.
// - Mode bits 7:6: 01 event count, 10 timer, 11 pulse width, 00 unused.
// - Event mode counts pin edges: falling if edge bit is 1, else rising.
// - Timer mode counts each prescaled tick while counting is enabled.
// - Counter runs up from its contents to FF, then reloads from preload.
// - Each overflow sets the request flag, bit 6 of interrupt control, with reload.
// - Pulse mode, edge bit 1: start on rising, stop on falling; 0 reversed.
// - Pulse mode clears the enable bit itself when the pin returns.
// - After one measurement the result holds; software re-arms via the enable bit.
// - Pulse counting starts on a pin transition, never on the static level.
// - Overflow during a pulse measurement reloads and requests like other modes.
// - Counting only while bit 4 is 1; only software clears it outside pulse mode.
// - Count write while disabled loads both preload and counter.
// - Count write while enabled loads only preload; counter takes it at overflow.
// - Reading the count register returns the live counter contents.
// - Counting is blocked during a count register read.
// - Counter overflow is a wake-up source.
// - Clearing the interrupt enable masks service; the flag still sets.
//
// The address-and-strobe port was chosen for this implementation.
`include "timer_one_consts.svh"

module timer_one #(
  parameter int WIDTH = 8,
  parameter int PRESCALE_BITS = 8
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic TIMER_PIN,
  input wire logic RTC_CLK,
  output logic OVERFLOW_FLAG,
  output logic OVERFLOW_IRQ,
  output logic WAKEUP,
  output logic COUNT_ENABLE
);

  timer_one_pkg::bus_req_t req;
  timer_one_pkg::control_t control_reg;
  timer_one_pkg::control_t control_next;
  timer_one_pkg::pulse_state_t pw_state_reg;
  timer_one_pkg::pulse_state_t pw_state_next;

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic [WIDTH-1:0] preload_reg;
  logic [PRESCALE_BITS-1:0] div_reg;
  logic [PRESCALE_BITS-1:0] div_mask;
  logic pin_prev_reg;
  logic rtc_prev_reg;
  logic flag_reg;
  logic flag_next;
  logic irq_enable_reg;
  logic irq_enable_next;
  logic [7:0] rdata_reg;
  logic wake_reg;
  logic irq_reg;

  logic pin_rise;
  logic pin_fall;
  logic src_tick;
  logic int_tick;
  logic count_block;
  logic pw_start;
  logic pw_stop;
  logic inc;
  logic overflow;
  logic wr_count;
  logic wr_control;
  logic wr_intctl;

  assign req.addr = ADDR;
  assign req.wdata = WDATA;
  assign req.wr = WR;
  assign req.rd = RD;

  assign wr_count = req.wr && (req.addr == `T1_ADDR_COUNT);
  assign wr_control = req.wr && (req.addr == `T1_ADDR_CONTROL);
  assign wr_intctl = req.wr && (req.addr == `T1_ADDR_INTCTL);

  // Edge detection on the timer pin and the 32 kHz clock level
  assign pin_rise = TIMER_PIN && !pin_prev_reg;
  assign pin_fall = !TIMER_PIN && pin_prev_reg;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      pin_prev_reg <= 1'b0;
      rtc_prev_reg <= 1'b0;
    end else if (CE) begin
      pin_prev_reg <= TIMER_PIN;
      rtc_prev_reg <= RTC_CLK;
    end
  end

  // Source tick: every enabled cycle, or one per rising edge of the 32 kHz clock
  always_comb begin
    if (control_reg.clock_source_select) begin
      src_tick = RTC_CLK && !rtc_prev_reg;
    end else begin
      src_tick = 1'b1;
    end
  end

  // Divide by 2^(code+1): tick when the low code+1 divider bits are all ones
  genvar gi;
  generate
    for (gi = 0; gi < PRESCALE_BITS; gi++) begin : g_mask
      assign div_mask[gi] = (gi <= int'(control_reg.prescale));
    end
  endgenerate

  assign int_tick = src_tick && ((div_reg & div_mask) == div_mask);

  // Free-running so a change of prescale code takes effect without a restart
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      div_reg <= '0;
    end else if (CE && src_tick) begin
      div_reg <= div_reg + PRESCALE_BITS'(1);
    end
  end

  // Reading the count freezes it for that cycle; the lost tick is not replayed
  assign count_block = req.rd && (req.addr == `T1_ADDR_COUNT);

  assign pw_start = control_reg.active_edge_select ? pin_rise : pin_fall;
  assign pw_stop = control_reg.active_edge_select ? pin_fall : pin_rise;

  // Increment decision per mode
  always_comb begin
    inc = 1'b0;
    if (control_reg.count_enable_bit && !count_block) begin
      unique case (control_reg.mode)
        timer_one_pkg::MODE_EVENT: begin
          inc = control_reg.active_edge_select ? pin_fall : pin_rise;
        end
        timer_one_pkg::MODE_TIMER: begin
          inc = int_tick;
        end
        timer_one_pkg::MODE_PULSE: begin
          inc = (pw_state_reg == timer_one_pkg::PW_COUNTING) && int_tick;
        end
        timer_one_pkg::MODE_UNUSED: begin
          inc = 1'b0;
        end
      endcase
    end
  end

  assign overflow = inc && (count_reg == `T1_COUNT_TOP);

  // Pulse-width measurement sequencer
  always_comb begin
    pw_state_next = pw_state_reg;
    if (control_reg.mode != timer_one_pkg::MODE_PULSE || !control_reg.count_enable_bit) begin
      // Disarmed: later edges are ignored until software sets enable again
      pw_state_next = timer_one_pkg::PW_WAIT_START;
    end else begin
      unique case (pw_state_reg)
        timer_one_pkg::PW_WAIT_START: begin
          if (pw_start) begin
            pw_state_next = timer_one_pkg::PW_COUNTING;
          end
        end
        timer_one_pkg::PW_COUNTING: begin
          if (pw_stop) begin
            pw_state_next = timer_one_pkg::PW_WAIT_START;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      pw_state_reg <= timer_one_pkg::PW_WAIT_START;
    end else if (CE) begin
      pw_state_reg <= pw_state_next;
    end
  end

  // Control register; hardware clears enable only at the end of a measurement
  always_comb begin
    control_next = control_reg;
    if (wr_control) begin
      control_next = timer_one_pkg::control_t'(req.wdata);
    end
    if (control_reg.mode == timer_one_pkg::MODE_PULSE && control_reg.count_enable_bit
        && pw_state_reg == timer_one_pkg::PW_COUNTING && pw_stop && !wr_control) begin
      control_next.count_enable_bit = 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      control_reg <= timer_one_pkg::control_t'(`T1_RESET_CONTROL);
    end else if (CE) begin
      control_reg <= control_next;
    end
  end

  // Preload is rewritten on every count write
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      preload_reg <= WIDTH'(`T1_RESET_PRELOAD);
    end else if (CE && wr_count) begin
      preload_reg <= WIDTH'(req.wdata);
    end
  end

  // Counter: direct load only while stopped, otherwise runs and reloads at overflow
  always_comb begin
    count_next = count_reg;
    if (overflow) begin
      count_next = preload_reg;
    end else if (inc) begin
      count_next = count_reg + WIDTH'(1);
    end
    if (wr_count && !control_reg.count_enable_bit) begin
      count_next = WIDTH'(req.wdata);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      count_reg <= WIDTH'(`T1_RESET_COUNT);
    end else if (CE) begin
      count_reg <= count_next;
    end
  end

  // Interrupt control: overflow set wins over a software clear in the same cycle
  always_comb begin
    flag_next = flag_reg;
    irq_enable_next = irq_enable_reg;
    if (wr_intctl) begin
      flag_next = req.wdata[`T1_BIT_IRQ_FLAG];
      irq_enable_next = req.wdata[`T1_BIT_IRQ_ENABLE];
    end
    if (overflow) begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      flag_reg <= 1'b0;
      irq_enable_reg <= 1'b0;
    end else if (CE) begin
      flag_reg <= flag_next;
      irq_enable_reg <= irq_enable_next;
    end
  end

  // Registered copies so every output leaves from a flip-flop
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else if (CE) begin
      irq_reg <= flag_next && irq_enable_next;
      wake_reg <= overflow;
    end
  end

  // Read port: data only in the cycle after the strobe, zero otherwise
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rdata_reg <= `T1_READ_ZERO;
    end else if (CE) begin
      rdata_reg <= `T1_READ_ZERO;
      if (req.rd) begin
        unique case (req.addr)
          `T1_ADDR_COUNT: begin
            rdata_reg <= 8'(count_reg);
          end
          `T1_ADDR_CONTROL: begin
            rdata_reg <= 8'(control_reg);
          end
          `T1_ADDR_INTCTL: begin
            rdata_reg <= `T1_READ_ZERO;
            rdata_reg[`T1_BIT_IRQ_FLAG] <= flag_reg;
            rdata_reg[`T1_BIT_IRQ_ENABLE] <= irq_enable_reg;
          end
          default: begin
            rdata_reg <= `T1_READ_ZERO;
          end
        endcase
      end
    end
  end

  assign RDATA = rdata_reg;
  assign OVERFLOW_FLAG = flag_reg;
  assign OVERFLOW_IRQ = irq_reg;
  assign WAKEUP = wake_reg;
  assign COUNT_ENABLE = control_reg.count_enable_bit;

endmodule

// ---- tb/pin_pulse_model.sv ----
// Purpose: Drives the timer pin with single pulses
// Assumes: Pin is a synchronous level
// Notes: IDLE sets the resting level, so both edge senses are reachable
module pin_pulse_model (
  input wire logic CLOCK,
  input wire logic GO,
  input wire logic IDLE,
  input wire logic [7:0] WIDTH,
  output logic PIN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_reg = 8'h00;
  always @(posedge CLOCK) begin
    if (GO) begin
      left_reg <= WIDTH;
    end else if (left_reg != 8'h00) begin
      left_reg <= left_reg - 8'h01;
    end
  end
  assign PIN = IDLE ^ (left_reg != 8'h00);
endmodule

// ---- tb/timer_one_chk.sv ----
// Purpose: Port checks for timer_one
// Assumes: Mode and interrupt enable are shadowed from bus writes
// Notes: Bound to every timer_one instance
module timer_one_chk (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic OVERFLOW_FLAG,
  input wire logic OVERFLOW_IRQ,
  input wire logic WAKEUP,
  input wire logic COUNT_ENABLE
);
  logic [1:0] mode_reg;
  logic ien_reg;
  logic wc;
  assign wc = WR && ADDR == 8'h11;
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      mode_reg <= 2'h0;
      ien_reg <= 1'b0;
    end else begin
      if (wc) begin
        mode_reg <= WDATA[7:6];
      end
      if (WR && ADDR == 8'h0B) begin
        ien_reg <= WDATA[3];
      end
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  AST_WAKE: assert property ($rose(OVERFLOW_FLAG) && !$past(WR) |-> ##[0:1] WAKEUP)
    else $error("no wake pulse after overflow");
  AST_WAKE_SRC: assert property (WAKEUP |-> OVERFLOW_FLAG || $past(WR) || $past(WR, 2))
    else $error("wake pulse without overflow");
  AST_IRQ: assert property (OVERFLOW_IRQ == (OVERFLOW_FLAG && ien_reg))
    else $error("irq differs from flag and enable");
  AST_RD_IDLE: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside read slot");
  AST_EN_WRITE: assert property (wc |=> COUNT_ENABLE == $past(WDATA[4]))
    else $error("enable not taken from write");
  AST_EN_RISE: assert property ($rose(COUNT_ENABLE) |-> $past(wc && WDATA[4]))
    else $error("enable set without write");
  AST_EN_FALL: assert property ($fell(COUNT_ENABLE) && $past(mode_reg) != 2'h3 |-> $past(wc))
    else $error("enable cleared by hardware");
  AST_FLAG_HOLD: assert property (OVERFLOW_FLAG && !(WR && ADDR == 8'h0B) |=> OVERFLOW_FLAG)
    else $error("flag dropped without write");
  AST_IDLE_MODE: assert property ($rose(OVERFLOW_FLAG) |-> $past(mode_reg) != 2'h0 || $past(WR))
    else $error("overflow in unused mode");
  cover property ($rose(OVERFLOW_IRQ));
  cover property ($fell(COUNT_ENABLE) && mode_reg == 2'h3);
  cover property (RD ##1 RDATA != 8'h00);
endmodule

bind timer_one timer_one_chk chk_u (.CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .OVERFLOW_FLAG(OVERFLOW_FLAG),
  .OVERFLOW_IRQ(OVERFLOW_IRQ), .WAKEUP(WAKEUP), .COUNT_ENABLE(COUNT_ENABLE));

// ---- tb/timer_one_tb.sv ----
// Purpose: Self-checking bench for timer_one
// Assumes: CE held high; interrupt control at 0x0B
// Notes: Tick periods are measured between wake pulses
module timer_one_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rtc = 1'b0;
  logic go = 1'b0;
  logic idle = 1'b0;
  logic [7:0] width = 8'h03;
  logic pin, flag, irq, wake, en;
  logic [7:0] rdata;
  logic [7:0] d;
  int bad_count = 0;
  int n_checks = 0;
  int k;
  always #12.5 clock = ~clock;
  // Off-grid half period keeps the slow clock unrelated in phase
  always #15259 rtc = ~rtc;
  timer_one dut_u (.CLOCK(clock), .RST_N(rst_n), .CE(1'b1), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .TIMER_PIN(pin), .RTC_CLK(rtc),
    .OVERFLOW_FLAG(flag), .OVERFLOW_IRQ(irq), .WAKEUP(wake), .COUNT_ENABLE(en));
  pin_pulse_model pin_u (.CLOCK(clock), .GO(go), .IDLE(idle), .WIDTH(width), .PIN(pin));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrt(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    d = rdata;
  endtask
  task automatic pulse();
    @(posedge clock);
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    repeat (width + 4) @(posedge clock);
  endtask
  task automatic wait_w(input int lim);
    k = 0;
    do begin
      @(negedge clock);
      k++;
      if (k > lim) begin
        chk("wakeup", 8'h01, 8'h00);
        finish_test();
      end
    end while (wake !== 1'b1);
  endtask
  task automatic t_regs();
    rdc(8'h11);
    chk("control reset", 8'h00, d);
    rdc(8'h20);
    chk("unmapped read", 8'h00, d);
    wrt(8'h10, 8'hFD);
    rdc(8'h10);
    chk("count load", 8'hFD, d);
    wrt(8'h11, 8'h27);
    rdc(8'h11);
    chk("control readback", 8'h27, d);
    wrt(8'h11, 8'h10);
    repeat (30) @(posedge clock);
    rdc(8'h10);
    chk("unused mode count", 8'hFD, d);
    $display("regs test done");
  endtask
  task automatic t_event(input logic e);
    wrt(8'h11, 8'h00);
    wrt(8'h10, 8'hFE);
    wrt(8'h0B, 8'h00);
    // Edge select sits at bit 3, above the three prescale bits
    wrt(8'h11, {4'b0101, e, 3'b000});
    pulse();
    rdc(8'h10);
    chk("event count", 8'hFF, d);
    wrt(8'h10, 8'hF0);
    rdc(8'h10);
    chk("running write", 8'hFF, d);
    pulse();
    rdc(8'h10);
    chk("reload", 8'hF0, d);
    chk("flag", 8'h01, {7'h00, flag});
    $display("event test done");
  endtask
  task automatic t_timer();
    for (int n = 0; n < 8; n++) begin
      wrt(8'h11, 8'h00);
      wrt(8'h10, 8'hFF);
      wrt(8'h0B, 8'h08);
      wrt(8'h11, 8'h90 | n[7:0]);
      wait_w(600);
      wait_w(600);
      chk("tick period", 8'h01, {7'h00, k == (2 << n)});
    end
    chk("irq", 8'h01, {7'h00, irq});
    wrt(8'h0B, 8'h00);
    wait_w(600);
    chk("masked irq", 8'h00, {7'h00, irq});
    wrt(8'h11, 8'hB0);
    wait_w(3000);
    wait_w(3000);
    chk("slow period", 8'h01, {7'h00, k > 2430 && k < 2450});
    $display("timer test done");
  endtask
  task automatic t_pulse(input logic e);
    wrt(8'h11, 8'h00);
    @(posedge clock);
    idle <= ~e;
    width <= 8'd20;
    wrt(8'h10, 8'h00);
    wrt(8'h11, {4'b1101, e, 3'b000});
    repeat (10) @(posedge clock);
    rdc(8'h10);
    chk("static level", 8'h00, d);
    pulse();
    chk("auto clear", 8'h00, {7'h00, en});
    rdc(8'h10);
    chk("width", 8'h01, {7'h00, d > 7 && d < 12});
    k = d;
    pulse();
    rdc(8'h10);
    chk("held result", k[7:0], d);
    $display("pulse test done");
  endtask
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_event(1'b0);
    t_event(1'b1);
    t_timer();
    t_pulse(1'b1);
    t_pulse(1'b0);
    finish_test();
  end
endmodule
